// ==== design/plm_pkg.sv ====
package plm_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SEC_NS = 1_000_000_000;
   localparam int SEC_CYC = SEC_NS / CLK_PERIOD_NS;
   // Least times round up: a count must pass the figure by one tick
   localparam int TEST_MIN = 15;
   localparam int TEST_TICKS = TEST_MIN * 60 + 1;
   localparam int HOLD_S = 5;
   localparam int HOLD_TICKS = HOLD_S + 1;
   localparam int HVAC_HOLD_MIN = 5;
   localparam int HVAC_HOLD_TICKS = HVAC_HOLD_MIN * 60 + 1;

   // ----------------------------------------
   // Widths and sizes
   // ----------------------------------------
   localparam int NLOADS = 6;
   localparam int NPWR = 4;
   localparam int LVL_W = 3;
   localparam int PCT_W = 7;
   localparam int GAP_W = 7;
   localparam int HVS_W = 9;
   localparam int TST_W = 10;
   localparam int HLD_W = 3;
   localparam int NPWR_STEP = 6;
   localparam int NHVAC_STEP = 5;

   // ----------------------------------------
   // Add delay tables, fastest entry first
   // ----------------------------------------
   localparam logic [PCT_W-1:0] PWR_PCT [NPWR_STEP] = '{7'h46, 7'h32, 7'h25, 7'h1E, 7'h14, 7'h05};
   localparam logic [GAP_W-1:0] PWR_SEC [NPWR_STEP] = '{7'h0F, 7'h17, 7'h22, 7'h28, 7'h30, 7'h3C};
   localparam logic [PCT_W-1:0] HVAC_PCT [NHVAC_STEP] = '{7'h46, 7'h32, 7'h25, 7'h1E, 7'h14};
   localparam logic [GAP_W-1:0] HVAC_SEC [NHVAC_STEP] = '{7'h1E, 7'h42, 7'h5B, 7'h66, 7'h78};

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CAPMAX = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_AVAIL = 4'h8;
   localparam logic [PCT_W-1:0] CAP_MAX_RST = 7'h46;
   localparam int ST_RELAY_LSB = 0;
   localparam int ST_MODE_LSB = 6;
   localparam int ST_CNT_LSB = 8;
   localparam int ST_TLVL_LSB = 11;

   // ----------------------------------------
   // Modes and defaults
   // ----------------------------------------
   localparam logic [1:0] GEN_OFF = 2'h0;
   localparam logic [1:0] GEN_AUTO = 2'h1;
   localparam logic [1:0] GEN_RUN = 2'h2;
   // Priority level per load, load 0 in the low bits: A..D then HVAC A, B
   localparam logic [NLOADS*LVL_W-1:0] LOAD_LVL_DEF = 18'h358D1;

   typedef enum logic [1:0] {
      M_UTIL = 2'b00,
      M_SHED = 2'b01,
      M_EMERG = 2'b10,
      M_TEST = 2'b11
   } plm_mode_e;

endpackage : plm_pkg

// ==== design/plm_dly_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface plm_dly_if;
   import plm_pkg::*;
   logic [PCT_W-1:0] avail;
   logic [GAP_W-1:0] pwr_sec;
   logic pwr_ok;
   logic [GAP_W-1:0] hvac_sec;
   logic hvac_ok;
   modport lut (input avail, output pwr_sec, pwr_ok, hvac_sec, hvac_ok);
   modport mgr (output avail, input pwr_sec, pwr_ok, hvac_sec, hvac_ok);
endinterface : plm_dly_if
`default_nettype wire

// ==== design/plm_dly_lut.sv ====
`timescale 1ns/1ps
`default_nettype none
module plm_dly_lut import plm_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Capacity in, delays out
   plm_dly_if.lut dly
);

   logic [GAP_W-1:0] p_sec;
   logic [GAP_W-1:0] h_sec;
   logic p_ok;
   logic h_ok;

   // ----------------------------------------
   // Lookup, slowest entry checked first
   // ----------------------------------------
   // Between points the slower entry wins, so delay never falls as capacity drops
   always_comb begin
      p_sec = PWR_SEC[NPWR_STEP-1];
      p_ok = 1'b0;
      h_sec = HVAC_SEC[NHVAC_STEP-1];
      h_ok = 1'b0;
      for (int i = NPWR_STEP - 1; i >= 0; i--) begin
         if (dly.avail >= PWR_PCT[i]) begin
            p_sec = PWR_SEC[i];
            p_ok = 1'b1;
         end
      end
      for (int i = NHVAC_STEP - 1; i >= 0; i--) begin
         if (dly.avail >= HVAC_PCT[i]) begin
            h_sec = HVAC_SEC[i];
            h_ok = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dly.pwr_sec <= PWR_SEC[NPWR_STEP-1];
         dly.pwr_ok <= 1'b0;
         dly.hvac_sec <= HVAC_SEC[NHVAC_STEP-1];
         dly.hvac_ok <= 1'b0;
      end else begin
         dly.pwr_sec <= p_sec;
         dly.pwr_ok <= p_ok;
         dly.hvac_sec <= h_sec;
         dly.hvac_ok <= h_ok;
      end
   end

endmodule : plm_dly_lut
`default_nettype wire

// ==== design/plm_top.sv ====
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module plm_top import plm_pkg::*; #(
   parameter int SEC_CYCLES = SEC_CYC,
   parameter logic [NLOADS*LVL_W-1:0] LOAD_LVL = LOAD_LVL_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Sources and switch position
   input wire logic utility_avail,
   input wire logic sw_normal,
   input wire logic gen_avail,
   input wire logic sw_emerg,
   // Generator controller
   input wire logic [1:0] gen_mode,
   input wire logic [PCT_W-1:0] load_pct,
   input wire logic shed_req,
   // Panel
   input wire logic test_btn,
   output logic led_util_avail,
   output logic led_util_conn,
   output logic led_gen_avail,
   output logic led_gen_conn,
   output logic [NLOADS-1:0] led_red,
   output logic [NLOADS-1:0] led_green,
   // Load relays, A..D then HVAC A, B
   output logic [NLOADS-1:0] relay_on
);

   localparam int PRE_W = $clog2(SEC_CYCLES + 1);

   function automatic logic [LVL_W-1:0] lvl_of(input int j);
      return LOAD_LVL[j*LVL_W +: LVL_W];
   endfunction : lvl_of

   plm_mode_e mode_reg;
   plm_mode_e mode_next;
   logic [LVL_W-1:0] add_cnt_reg;
   logic [LVL_W-1:0] test_lvl_reg;
   logic [PRE_W-1:0] pre_reg;
   logic [GAP_W-1:0] gap_reg;
   logic [HVS_W-1:0] hvac_s_reg;
   logic [TST_W-1:0] test_s_reg;
   logic [HLD_W-1:0] hold_reg;
   logic [PCT_W-1:0] cap_max_reg;
   logic [PCT_W-1:0] avail_reg;
   logic [NLOADS-1:0] relay_reg;
   logic [NLOADS-1:0] relay_next;
   logic [NLOADS-1:0] test_sel;
   logic [NLOADS-1:0] red_reg;
   logic [NLOADS-1:0] green_reg;
   logic [3:0] src_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_word;
   logic sec_tick;
   logic blink_reg;
   logic btn_d_reg;
   logic btn_rise;
   logic nxt_hvac;
   logic add_go;
   logic shed_go;
   logic test_enter;
   logic test_exit;

   plm_dly_if dly ();

   plm_dly_lut u_lut (
      .clk(clk),
      .rst_b(rst_b),
      .dly(dly.lut)
   );

   // ----------------------------------------
   // Second tick and panel button
   // ----------------------------------------
   // A free-running tick: second counts are good to one tick, hence the +1 figures
   assign sec_tick = (pre_reg == PRE_W'(SEC_CYCLES - 1));
   assign btn_rise = test_btn & ~btn_d_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_reg <= '0;
      end else if (sec_tick) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + PRE_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         blink_reg <= 1'b0;
         btn_d_reg <= 1'b0;
      end else begin
         btn_d_reg <= test_btn;
         if (sec_tick) begin
            blink_reg <= ~blink_reg;
         end
      end
   end

   // ----------------------------------------
   // Capacity
   // ----------------------------------------
   assign dly.avail = avail_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avail_reg <= '0;
      end else if (cap_max_reg > load_pct) begin
         avail_reg <= cap_max_reg - load_pct;
      end else begin
         avail_reg <= '0;
      end
   end

   // ----------------------------------------
   // Add and shed decisions
   // ----------------------------------------
   always_comb begin
      nxt_hvac = 1'b0;
      for (int j = NPWR; j < NLOADS; j++) begin
         if (lvl_of(j) == add_cnt_reg + LVL_W'(1)) begin
            nxt_hvac = 1'b1;
         end
      end
   end

   // Gap counts from the last add or shed; an HVAC gap starts only once the hold-off is over
   assign add_go = (mode_reg == M_EMERG) && (add_cnt_reg < LVL_W'(NLOADS)) &&
                   (nxt_hvac ? (dly.hvac_ok && (gap_reg > dly.hvac_sec) &&
                                (hvac_s_reg >= HVS_W'(HVAC_HOLD_TICKS))) :
                               (dly.pwr_ok && (gap_reg > dly.pwr_sec)));
   assign shed_go = (mode_reg == M_EMERG) && shed_req && (add_cnt_reg != '0);
   // Test is only offered with the generator in manual run and the switch on utility
   assign test_enter = (mode_reg == M_UTIL) && btn_rise && (gen_mode == GEN_RUN) &&
                       !sw_emerg && utility_avail;
   assign test_exit = (mode_reg == M_TEST) &&
                      ((test_s_reg >= TST_W'(TEST_TICKS)) ||
                       (hold_reg >= HLD_W'(HOLD_TICKS)) ||
                       (gen_mode == GEN_OFF) || (gen_mode == GEN_AUTO) ||
                       !utility_avail || sw_emerg);

   // ----------------------------------------
   // Operating mode
   // ----------------------------------------
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         M_UTIL: begin
            if (sw_emerg || !utility_avail) begin
               mode_next = M_SHED;
            end else if (test_enter) begin
               mode_next = M_TEST;
            end
         end
         M_SHED: begin
            if (sw_emerg) begin
               mode_next = M_EMERG;
            end else if (utility_avail && sw_normal) begin
               mode_next = M_UTIL;
            end
         end
         M_EMERG: begin
            if (sw_normal) begin
               mode_next = M_UTIL;
            end
         end
         M_TEST: begin
            if (test_exit) begin
               mode_next = M_UTIL;
            end
         end
         default: mode_next = M_UTIL;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= M_UTIL;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Levels 1..add_cnt are connected; adds climb, sheds drop the highest level first
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         add_cnt_reg <= LVL_W'(NLOADS);
      end else begin
         case (mode_next)
            M_SHED: add_cnt_reg <= '0;
            M_EMERG: begin
               // A shed request beats a pending add: relief comes before more load
               if (shed_go) begin
                  add_cnt_reg <= add_cnt_reg - LVL_W'(1);
               end else if (add_go) begin
                  add_cnt_reg <= add_cnt_reg + LVL_W'(1);
               end
            end
            default: add_cnt_reg <= LVL_W'(NLOADS);
         endcase
      end
   end

   // ----------------------------------------
   // Timers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_reg <= '0;
      end else if ((mode_reg != M_EMERG) || add_go || shed_go) begin
         gap_reg <= '0;
      end else if (nxt_hvac && (hvac_s_reg < HVS_W'(HVAC_HOLD_TICKS))) begin
         gap_reg <= '0;
      end else if (sec_tick && (gap_reg != '1)) begin
         gap_reg <= gap_reg + GAP_W'(1);
      end
   end

   // Runs from the moment power load A is on; any full shed restarts it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hvac_s_reg <= HVS_W'(HVAC_HOLD_TICKS);
      end else if (!relay_reg[0]) begin
         hvac_s_reg <= '0;
      end else if (sec_tick && (hvac_s_reg < HVS_W'(HVAC_HOLD_TICKS))) begin
         hvac_s_reg <= hvac_s_reg + HVS_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         test_s_reg <= '0;
      end else if (mode_reg != M_TEST) begin
         test_s_reg <= '0;
      end else if (sec_tick) begin
         test_s_reg <= test_s_reg + TST_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_reg <= '0;
      end else if (!test_btn) begin
         hold_reg <= '0;
      end else if (sec_tick && (hold_reg < HLD_W'(HOLD_TICKS))) begin
         hold_reg <= hold_reg + HLD_W'(1);
      end
   end

   // ----------------------------------------
   // Test relay selection
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         test_lvl_reg <= '0;
      end else if (test_enter) begin
         test_lvl_reg <= LVL_W'(1);
      end else if ((mode_reg == M_TEST) && !test_exit && btn_rise) begin
         if (test_lvl_reg == LVL_W'(NLOADS)) begin
            test_lvl_reg <= LVL_W'(1);
         end else begin
            test_lvl_reg <= test_lvl_reg + LVL_W'(1);
         end
      end else if (mode_next != M_TEST) begin
         test_lvl_reg <= '0;
      end
   end

   // ----------------------------------------
   // Relays and LEDs
   // ----------------------------------------
   always_comb begin
      for (int j = 0; j < NLOADS; j++) begin
         test_sel[j] = (mode_reg == M_TEST) && (test_lvl_reg == lvl_of(j));
         relay_next[j] = (lvl_of(j) != '0) && (lvl_of(j) <= add_cnt_reg) && !test_sel[j];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         relay_reg <= '0;
         red_reg <= '1;
         green_reg <= '0;
      end else begin
         relay_reg <= relay_next;
         green_reg <= relay_next;
         for (int j = 0; j < NLOADS; j++) begin
            red_reg[j] <= test_sel[j] ? blink_reg : !relay_next[j];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         src_reg <= '0;
      end else begin
         src_reg[0] <= utility_avail;
         src_reg[1] <= sw_normal;
         src_reg[2] <= gen_avail;
         src_reg[3] <= sw_emerg;
      end
   end

   assign led_util_avail = src_reg[0];
   assign led_util_conn = src_reg[1];
   assign led_gen_avail = src_reg[2];
   assign led_gen_conn = src_reg[3];
   assign led_red = red_reg;
   assign led_green = green_reg;
   assign relay_on = relay_reg;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cap_max_reg <= CAP_MAX_RST;
      end else if (reg_wr && (reg_addr == REG_CAPMAX)) begin
         cap_max_reg <= reg_wdata[PCT_W-1:0];
      end
   end

   always_comb begin
      rd_word = '0;
      case (reg_addr)
         REG_CAPMAX: rd_word[PCT_W-1:0] = cap_max_reg;
         REG_STATUS: begin
            rd_word[ST_RELAY_LSB +: NLOADS] = relay_reg;
            rd_word[ST_MODE_LSB +: 2] = mode_reg;
            rd_word[ST_CNT_LSB +: LVL_W] = add_cnt_reg;
            rd_word[ST_TLVL_LSB +: LVL_W] = test_lvl_reg;
         end
         REG_AVAIL: rd_word[PCT_W-1:0] = avail_reg;
         default: rd_word = '0;
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= '0;
      end else if (reg_rd) begin
         rdata_reg <= rd_word;
      end else begin
         rdata_reg <= '0;
      end
   end

   assign reg_rdata = rdata_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_util_leds: assert property ($past(rst_b) |-> (led_util_avail == $past(utility_avail)) &&
                                   (led_util_conn == $past(sw_normal)))
      else $error("utility LEDs do not follow inputs");
   chk_gen_leds: assert property ($past(rst_b) |-> (led_gen_avail == $past(gen_avail)) &&
                                  (led_gen_conn == $past(sw_emerg)))
      else $error("generator LEDs do not follow inputs");
   chk_load_leds: assert property (((led_red & led_green) == '0) && (led_green == relay_on))
      else $error("load LED disagrees with relay");
   chk_test_step: assert property ((mode_reg == M_TEST && btn_rise && !test_exit &&
                                    test_lvl_reg != LVL_W'(NLOADS)) |=>
                                   (test_lvl_reg == $past(test_lvl_reg) + LVL_W'(1)))
      else $error("test press did not advance relay");
   chk_test_limit: assert property ((mode_reg == M_TEST) |-> (test_s_reg <= TST_W'(TEST_TICKS)))
      else $error("test mode outlived its limit");
   chk_hold_exit: assert property ((mode_reg == M_TEST && hold_reg == HLD_W'(HOLD_TICKS)) |=>
                                   (mode_reg == M_UTIL) ##1 (&relay_on))
      else $error("held button did not end test");
   chk_gen_exit: assert property ((mode_reg == M_TEST && (gen_mode == GEN_OFF || gen_mode == GEN_AUTO)) |=>
                                  (mode_reg == M_UTIL))
      else $error("generator mode did not end test");
   chk_add_gap: assert property ((mode_reg == M_EMERG && add_go) |->
                                 (gap_reg >= GAP_W'(16)) && (nxt_hvac || dly.pwr_ok))
      else $error("load added too soon");
   chk_hvac_hold: assert property ((add_go && nxt_hvac) |->
                                   (hvac_s_reg > HVS_W'(HVAC_HOLD_TICKS - 1)) && relay_reg[0])
      else $error("HVAC added inside hold-off");
   chk_shed_all: assert property (($past(mode_reg) == M_UTIL && mode_reg == M_SHED) |->
                                  (add_cnt_reg == '0) ##1 (relay_on == '0))
      else $error("transfer did not shed all loads");
   chk_shed_order: assert property ((shed_go && mode_next == M_EMERG) |=>
                                    (add_cnt_reg == $past(add_cnt_reg) - LVL_W'(1)))
      else $error("shed did not drop one level");
   chk_retransfer: assert property ((mode_reg == M_EMERG && sw_normal) |=>
                                    (add_cnt_reg == LVL_W'(NLOADS)))
      else $error("retransfer did not add all loads");

endmodule : plm_top
`default_nettype wire

// ==== test/plm_gen_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Generator controller and switch model
// ----------------------------------------
module plm_gen_model import plm_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Commands from the bench
   input wire logic outage,
   input wire logic run_req,
   input wire logic [PCT_W-1:0] load_set,
   // Toward the block
   output logic utility_avail,
   output logic sw_normal,
   output logic gen_avail,
   output logic sw_emerg,
   output logic [1:0] gen_mode,
   output logic [PCT_W-1:0] load_pct
);
   logic [3:0] start_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         start_reg <= 4'h0;
         utility_avail <= 1'b1;
         sw_normal <= 1'b1;
         gen_avail <= 1'b0;
         sw_emerg <= 1'b0;
         gen_mode <= GEN_AUTO;
         load_pct <= 7'h00;
      end else begin
         if (!outage) begin
            start_reg <= 4'h0;
         end else if (start_reg != 4'hF) begin
            start_reg <= start_reg + 4'h1;
         end
         utility_avail <= !outage;
         load_pct <= load_set;
         // Manual run keeps the set running; a test run never transfers
         gen_mode <= run_req ? GEN_RUN : GEN_AUTO;
         gen_avail <= run_req || (outage && start_reg > 4'h4);
         sw_normal <= !outage;
         // Switch moves only after the set has come up, never for a
         sw_emerg <= outage && start_reg > 4'h8;
      end
   end
endmodule : plm_gen_model
`default_nettype wire

// ==== test/priority_load_add_manager_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module priority_load_add_manager_tb_top;
   import plm_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   // Short second keeps the fifteen-minute test exit within reach
   localparam int SC = 10;
   logic clk, rst_b, reg_wr, reg_rd, shed_req, test_btn, outage, run_req;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic utility_avail, sw_normal, gen_avail, sw_emerg;
   logic [1:0] gen_mode;
   logic [PCT_W-1:0] load_pct, load_set;
   logic lua, luc, lga, lgc, r0;
   logic [NLOADS-1:0] led_red, led_green, relay_on;
   int err_total, samples_checked, cyc, t0, tp, cap, v;
   plm_top #(.SEC_CYCLES(SC), .LOAD_LVL(LOAD_LVL_DEF)) plm_top_inst (.clk(clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .utility_avail(utility_avail), .sw_normal(sw_normal), .gen_avail(gen_avail), .sw_emerg(sw_emerg),
      .gen_mode(gen_mode), .load_pct(load_pct), .shed_req(shed_req), .test_btn(test_btn),
      .led_util_avail(lua), .led_util_conn(luc), .led_gen_avail(lga), .led_gen_conn(lgc),
      .led_red(led_red), .led_green(led_green), .relay_on(relay_on));
   plm_gen_model plm_gen_model_inst (.clk(clk), .rst_b(rst_b), .outage(outage), .run_req(run_req),
      .load_set(load_set), .utility_avail(utility_avail), .sw_normal(sw_normal), .gen_avail(gen_avail),
      .sw_emerg(sw_emerg), .gen_mode(gen_mode), .load_pct(load_pct));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [NLOADS-1:0] lvl_mask(input int n);
      logic [NLOADS-1:0] m;
      for (int i = 0; i < NLOADS; i++) m[i] = int'(LOAD_LVL_DEF[i*LVL_W +: LVL_W]) <= n;
      return m;
   endfunction : lvl_mask
   function automatic logic [31:0] exp_avail(input int c, input int l);
      return (c > l) ? 32'(c - l) : 32'h0;
   endfunction : exp_avail
   task automatic fail(input string s);
      err_total++;
      $display("Error at %0t: %s", $time, s);
   endtask : fail
   task automatic chk_vec(input logic [NLOADS-1:0] got, input logic [NLOADS-1:0] exp);
      samples_checked++;
      if (got !== exp) fail($sformatf("vector %b expected %b", got, exp));
   endtask : chk_vec
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
   endtask : chk_word
   task automatic chk_range(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) fail($sformatf("interval %0d outside %0d..%0d", got, lo, hi));
   endtask : chk_range
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] w);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : reg_read
   task automatic wait_change(input int lim);
      logic [NLOADS-1:0] p;
      int n;
      p = relay_on;
      n = 0;
      while (relay_on === p && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) fail("relays never changed");
   endtask : wait_change
   task automatic press();
      @(posedge clk) test_btn <= 1'b1;
      @(posedge clk) test_btn <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : press
   task automatic final_report();
      $display("Checks %0d, errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail("timeout");
         final_report();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      {rst_b, reg_wr, reg_rd, shed_req, test_btn, outage, run_req} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      load_set = '0;
      void'($urandom(9));
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      chk_vec(relay_on & led_green & ~led_red, '1);
      chk_vec({2'b0, lua, luc, lga, lgc}, 6'h0C);
      reg_read(REG_CAPMAX);
      chk_word(d, 32'h46);
      for (int i = 0; i < 5; i++) begin
         v = (i == 0) ? 60 : int'($urandom % 71);
         cap = (i == 0) ? 20 : 40 + int'($urandom % 31);
         load_set <= PCT_W'(v);
         reg_write(REG_CAPMAX, 32'(cap));
         repeat (4) @(posedge clk);
         reg_read(REG_AVAIL);
         chk_word(d, exp_avail(cap, v));
      end
      load_set <= 7'h00;
      reg_write(REG_CAPMAX, 32'h46);
      @(posedge clk) outage <= 1'b1;
      repeat (4) @(posedge clk);
      chk_vec(relay_on, 6'h00);
      chk_vec(led_red, 6'h3F);
      while (!lgc) @(posedge clk);
      chk_vec({2'b0, lua, luc, lga, lgc}, 6'h03);
      for (int n = 1; n <= NLOADS; n++) begin
         tp = cyc;
         wait_change(400 * SC);
         chk_vec(relay_on, lvl_mask(n));
         if (n == 1) t0 = cyc;
         if (n > 1 && n < 5) chk_range(cyc - tp, 15 * SC, 17 * SC + 4);
         if (n == 5) chk_range(cyc - t0, 330 * SC, 334 * SC + 4);
         if (n == 6) chk_range(cyc - tp, 30 * SC, 32 * SC + 4);
      end
      @(posedge clk) shed_req <= 1'b1;
      @(posedge clk) shed_req <= 1'b0;
      repeat (3) @(posedge clk);
      chk_vec(relay_on, lvl_mask(5));
      chk_vec(led_red, ~lvl_mask(5));
      load_set <= 7'h42;
      repeat (80 * SC) @(posedge clk);
      chk_vec(relay_on, lvl_mask(5));
      outage <= 1'b0;
      load_set <= 7'h00;
      repeat (5) @(posedge clk);
      chk_vec(relay_on, 6'h3F);
      @(posedge clk) run_req <= 1'b1;
      repeat (3) @(posedge clk);
      press();
      chk_vec(relay_on, 6'h3E);
      r0 = led_red[0];
      repeat (SC) @(posedge clk);
      chk_vec({5'b0, led_red[0] ^ r0}, 6'h01);
      press();
      chk_vec(relay_on, 6'h3D);
      @(posedge clk) test_btn <= 1'b1;
      repeat (7 * SC) @(posedge clk);
      chk_vec(relay_on & led_green & ~led_red, 6'h3F);
      test_btn <= 1'b0;
      repeat (3) @(posedge clk);
      press();
      chk_vec(relay_on, 6'h3E);
      reg_read(REG_STATUS);
      chk_word(d, 32'h3E | (32'(M_TEST) << ST_MODE_LSB) | (32'(NLOADS) << ST_CNT_LSB) |
               (32'h1 << ST_TLVL_LSB));
      @(posedge clk) run_req <= 1'b0;
      repeat (5) @(posedge clk);
      chk_vec(relay_on, 6'h3F);
      run_req <= 1'b1;
      repeat (3) @(posedge clk);
      press();
      repeat (896 * SC) @(posedge clk);
      chk_vec(relay_on, 6'h3E);
      repeat (5 * SC) @(posedge clk);
      chk_vec(relay_on, 6'h3F);
      final_report();
   end
endmodule : priority_load_add_manager_tb_top
`default_nettype wire
